// ### rte_far_end.sv
// Far-side model: the free-running slow crystal and an event user.
// Assumes the bench reads the count of overflow pulses seen.
`timescale 1ns/1ps
module rte_far_end #(
    parameter int HALF_NS = 32
) (
    // Slow timebase
    output logic           slow_clk_pin,
    // Event user
    input  wire logic      overflow_event,
    output int             ovf_seen
);
    // The crystal runs free, offset in phase from the system clock.
    initial begin
        slow_clk_pin = 1'b0;
        #3;
        forever #(HALF_NS) slow_clk_pin = ~slow_clk_pin;
    end
    // Each overflow pulse is counted once, as a routed event user would.
    initial ovf_seen = 0;
    always @(posedge overflow_event) ovf_seen = ovf_seen + 1;
endmodule // rte_far_end

// ### rte_pkg.sv
// Package for the real-time counter event, interrupt, sleep and halt block.
// Assumes a single system clock; the slow timebase arrives as a pin level.
package rte_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int CNT_W        = 16;  // Tick value, wrap limit and compare width.
    localparam int PRESC_W      = 15;  // Prescaler counter width.
    localparam int LEVEL_N      = 8;   // Number of divided level outputs.
    localparam int LEVEL_LSB    = 5;   // Prescaler bit of the divide-by-64 level.
    localparam int SYNC_STAGES  = 2;   // Slow-clock cycles before a write applies.

    // ------------------------------------------------------------------
    // Bit positions of the counter interrupt group
    // ------------------------------------------------------------------
    localparam int IRQ_OVF_BIT  = 0;
    localparam int IRQ_CMP_BIT  = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] PER_RST = 16'hffff;
    localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;

    // Main control register contents.
    typedef struct packed {
        logic       run_in_standby_bit;
        logic [3:0] prescaler;
        logic       enable;
    } rte_main_ctrl_t;

    // Periodic tick timer control register contents.
    typedef struct packed {
        logic [3:0] period;
        logic       enable;
    } rte_tick_ctrl_t;

    localparam rte_main_ctrl_t MAIN_CTRL_RST = '0;
    localparam rte_tick_ctrl_t TICK_CTRL_RST = '0;

    // Busy flags, in the order compare, wrap limit, tick value, main control.
    typedef struct packed {
        logic compare_sync_pending;
        logic wrap_limit_sync_pending;
        logic tick_value_sync_pending;
        logic main_control_sync_pending;
    } rte_busy_t;

    // Progress of one pending write across the slow domain.
    typedef struct packed {
        logic busy;
        logic stage;
    } rte_sync_t;

endpackage

// ### rte_top.sv
// Real-time counter core with events, two interrupt groups, sleep and halt gating.
// Assumes the slow timebase is a free-running pin level asynchronous to clk_sys,
// and much slower than clk_sys, so that each slow edge is seen once.
`timescale 1ns/1ps

// What this block does
// R01: Overflow, compare events pulse one slow period.
// R02: Eight level outputs, prescaler divided 64..8192.
// R03: Overflow when tick value wraps at limit.
// R04: Compare when tick value equals compare.
// R05: Tick timer flag per selected interval.
// R06: Flags set regardless of enable.
// R07: Each source has its own enable.
// R08: Request held while flag and enable set.
// R09: Counter and tick timer have separate groups.
// R10: Counter runs Idle; Standby only if allowed.
// R11: Tick timer runs in every sleep mode.
// R12: Writes apply after slow-domain synchronization.
// R13: Four busy flags for counter writes.
// R14: One busy flag for tick control.
// R15: Software waits for busy clear first.
// R16: Halted without debug-run stops counter.
// R17: Halted without debug-run holds tick output low.
// R18: Tick flag sets on output rising edge.
// R19: Prescaler change applies two slow cycles later.
// R20: First tick interrupt within one period.
// R21: Flags clear by writing one.
// R22: Busy sets on write, clears on acknowledge.
module rte_top (
    // Clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         reset_n,
    // Slow timebase pin, asynchronous
    input  wire logic                         slow_clk_pin,
    // Sleep and halt status
    input  wire logic                         sleep_idle,
    input  wire logic                         sleep_standby,
    input  wire logic                         cpu_halted,
    // Register writes, one-cycle strobes with data
    input  wire logic                         main_ctrl_wr,
    input  wire rte_pkg::rte_main_ctrl_t      main_ctrl_wdata,
    input  wire logic                         tick_ctrl_wr,
    input  wire rte_pkg::rte_tick_ctrl_t      tick_ctrl_wdata,
    input  wire logic                         compare_wr,
    input  wire logic [rte_pkg::CNT_W-1:0]    compare_wdata,
    input  wire logic                         wrap_limit_wr,
    input  wire logic [rte_pkg::CNT_W-1:0]    wrap_limit_wdata,
    input  wire logic                         tick_value_wr,
    input  wire logic [rte_pkg::CNT_W-1:0]    tick_value_wdata,
    // Interrupt enables, halt behaviour and flag clears
    input  wire logic [1:0]                   irq_enable_register,
    input  wire logic                         tick_irq_enable_register,
    input  wire logic                         keep_running_when_halted,
    input  wire logic                         tick_keep_running_when_halted,
    input  wire logic [1:0]                   irq_flag_clear,
    input  wire logic                         tick_irq_flag_clear,
    // Events
    output logic                              overflow_event,
    output logic                              compare_match,
    output logic [rte_pkg::LEVEL_N-1:0]       tick_levels,
    // Interrupt flags and requests
    output logic [1:0]                        irq_flag_register,
    output logic                              tick_irq_flag_register,
    output logic                              counter_irq,
    output logic                              tick_irq,
    // Status
    output rte_pkg::rte_busy_t                status_busy,
    output logic                              tick_control_sync_pending,
    output logic [rte_pkg::CNT_W-1:0]         tick_value
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]                      pin_sync;
        logic                            pin_last;
        rte_pkg::rte_main_ctrl_t         main_stage;
        rte_pkg::rte_main_ctrl_t         main_act;
        rte_pkg::rte_tick_ctrl_t         tick_stage;
        rte_pkg::rte_tick_ctrl_t         tick_act;
        logic [rte_pkg::CNT_W-1:0]       cmp_stage;
        logic [rte_pkg::CNT_W-1:0]       cmp_act;
        logic [rte_pkg::CNT_W-1:0]       per_stage;
        logic [rte_pkg::CNT_W-1:0]       per_act;
        logic [rte_pkg::CNT_W-1:0]       cnt_stage;
        logic [rte_pkg::CNT_W-1:0]       cnt;
        rte_pkg::rte_sync_t              sy_main;
        rte_pkg::rte_sync_t              sy_tick;
        rte_pkg::rte_sync_t              sy_cmp;
        rte_pkg::rte_sync_t              sy_per;
        rte_pkg::rte_sync_t              sy_cnt;
        logic [rte_pkg::PRESC_W-1:0]     presc;
        logic                            ovf_ev;
        logic                            cmp_ev;
        logic [rte_pkg::LEVEL_N-1:0]     levels;
        logic                            tick_out;
        logic [1:0]                      flags;
        logic                            tick_flag;
        logic                            cnt_irq;
        logic                            tk_irq;
    } rte_state_t;

    rte_state_t st_r;
    rte_state_t st_nxt;

    // Advances one pending write on a slow edge; returns the new progress.
    function automatic rte_pkg::rte_sync_t sync_step(input rte_pkg::rte_sync_t s,
                                                     input logic edge_seen);
        rte_pkg::rte_sync_t r;
        r = s;
        if (s.busy && edge_seen) begin
            if (!s.stage) begin
                r.stage = 1'b1;
            end else begin
                r = '0;
            end
        end
        return r;
    endfunction

    // True on the slow edge that completes a pending write.
    function automatic logic sync_done(input rte_pkg::rte_sync_t s, input logic edge_seen);
        return s.busy && s.stage && edge_seen;
    endfunction

    // Prescaler mask of all ones below the selected divide bit.
    function automatic logic [rte_pkg::PRESC_W-1:0] presc_mask(input logic [3:0] sel);
        logic [rte_pkg::PRESC_W:0] m;
        m = ({{rte_pkg::PRESC_W{1'b0}}, 1'b1} << sel) - 1'b1;
        return m[rte_pkg::PRESC_W-1:0];
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic slow_edge;
    logic cnt_tick;
    logic cnt_run;
    logic tick_hold;
    logic tick_now;
    logic [rte_pkg::CNT_W-1:0] cnt_next;

    // Computes every register of the block from the current state.
    always_comb begin
        st_nxt = st_r;
        cnt_next = st_r.cnt;
        // Two-flop synchroniser, then edge detection on the second stage only.
        st_nxt.pin_sync = {st_r.pin_sync[0], slow_clk_pin};
        st_nxt.pin_last = st_r.pin_sync[1];
        slow_edge = st_r.pin_sync[1] && !st_r.pin_last;

        // Slow-domain write progress; the busy bit clears once applied.  R12 R22
        st_nxt.sy_main = sync_step(st_r.sy_main, slow_edge);
        st_nxt.sy_tick = sync_step(st_r.sy_tick, slow_edge);
        st_nxt.sy_cmp  = sync_step(st_r.sy_cmp, slow_edge);
        st_nxt.sy_per  = sync_step(st_r.sy_per, slow_edge);
        st_nxt.sy_cnt  = sync_step(st_r.sy_cnt, slow_edge);
        // Staged values reach the slow logic on the second slow edge.  R19
        if (sync_done(st_r.sy_main, slow_edge)) begin
            st_nxt.main_act = st_r.main_stage;
        end
        if (sync_done(st_r.sy_tick, slow_edge)) begin
            st_nxt.tick_act = st_r.tick_stage;
        end
        if (sync_done(st_r.sy_cmp, slow_edge)) begin
            st_nxt.cmp_act = st_r.cmp_stage;
        end
        if (sync_done(st_r.sy_per, slow_edge)) begin
            st_nxt.per_act = st_r.per_stage;
        end

        // Bus-side writes capture data and raise busy on the accepting edge.  R13 R14 R22
        if (main_ctrl_wr) begin
            st_nxt.main_stage = main_ctrl_wdata;
            st_nxt.sy_main    = '{busy: 1'b1, stage: 1'b0};
        end
        if (tick_ctrl_wr) begin
            st_nxt.tick_stage = tick_ctrl_wdata;
            st_nxt.sy_tick    = '{busy: 1'b1, stage: 1'b0};
        end
        if (compare_wr) begin
            st_nxt.cmp_stage = compare_wdata;
            st_nxt.sy_cmp    = '{busy: 1'b1, stage: 1'b0};
        end
        if (wrap_limit_wr) begin
            st_nxt.per_stage = wrap_limit_wdata;
            st_nxt.sy_per    = '{busy: 1'b1, stage: 1'b0};
        end
        if (tick_value_wr) begin
            st_nxt.cnt_stage = tick_value_wdata;
            st_nxt.sy_cnt    = '{busy: 1'b1, stage: 1'b0};
        end

        // Halt and sleep gating of the counter; idle sleep never stops it.  R10 R16
        cnt_run = st_r.main_act.enable
               && !(sleep_standby && !st_r.main_act.run_in_standby_bit)
               && !(cpu_halted && !keep_running_when_halted);
        // Tick timer is gated by halt only, never by sleep.  R11 R17
        tick_hold = cpu_halted && !tick_keep_running_when_halted;

        // Shared prescaler runs while the counter is running or the tick timer is enabled.
        if (slow_edge && ((st_r.main_act.enable && cnt_run) || st_r.tick_act.enable)) begin
            st_nxt.presc = st_r.presc + 1'b1;
        end
        cnt_tick = slow_edge && cnt_run
                && ((st_r.presc & presc_mask(st_r.main_act.prescaler))
                    == presc_mask(st_r.main_act.prescaler));

        // Events last from one slow edge to the next.  R01
        if (slow_edge) begin
            st_nxt.ovf_ev = 1'b0;
            st_nxt.cmp_ev = 1'b0;
        end
        if (cnt_tick) begin
            if (st_r.cnt == st_r.per_act) begin
                cnt_next = '0;
                st_nxt.ovf_ev = 1'b1; // R03
            end else begin
                cnt_next = st_r.cnt + 1'b1;
            end
            st_nxt.cmp_ev = (cnt_next == st_r.cmp_act); // R04
        end
        // A synchronised tick value write overrides the count.
        if (sync_done(st_r.sy_cnt, slow_edge)) begin
            cnt_next = st_r.cnt_stage;
        end
        st_nxt.cnt = cnt_next;

        // Divided level outputs follow prescaler bits, low while held.  R02 R17
        for (int i = 0; i < rte_pkg::LEVEL_N; i++) begin
            st_nxt.levels[i] = st_r.presc[rte_pkg::LEVEL_LSB + i] && !tick_hold;
        end
        // Period field n selects prescaler bit n; zero selects nothing.  R05 R20
        tick_now = st_r.tick_act.enable && (st_r.tick_act.period != 4'h0)
                && st_r.presc[st_r.tick_act.period - 4'h1 + 4'h1] && !tick_hold;
        st_nxt.tick_out = tick_now;

        // Flags: clear by one, hardware set wins over the clear.  R06 R21
        st_nxt.flags = st_r.flags & ~irq_flag_clear;
        if (cnt_tick && st_nxt.ovf_ev) begin
            st_nxt.flags[rte_pkg::IRQ_OVF_BIT] = 1'b1; // R01
        end
        if (cnt_tick && st_nxt.cmp_ev) begin
            st_nxt.flags[rte_pkg::IRQ_CMP_BIT] = 1'b1; // R01
        end
        st_nxt.tick_flag = st_r.tick_flag && !tick_irq_flag_clear;
        if (tick_now && !st_r.tick_out) begin
            st_nxt.tick_flag = 1'b1; // R18
        end

        // Two separate requests, each flag gated by its own enable.  R07 R08 R09
        st_nxt.cnt_irq = |(st_nxt.flags & irq_enable_register);
        st_nxt.tk_irq  = st_nxt.tick_flag && tick_irq_enable_register;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Registers the whole state; reset loads constants only.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_r            <= '0;
            st_r.main_stage <= rte_pkg::MAIN_CTRL_RST;
            st_r.main_act   <= rte_pkg::MAIN_CTRL_RST;
            st_r.tick_stage <= rte_pkg::TICK_CTRL_RST;
            st_r.tick_act   <= rte_pkg::TICK_CTRL_RST;
            st_r.cmp_stage  <= rte_pkg::CMP_RST;
            st_r.cmp_act    <= rte_pkg::CMP_RST;
            st_r.per_stage  <= rte_pkg::PER_RST;
            st_r.per_act    <= rte_pkg::PER_RST;
            st_r.cnt_stage  <= rte_pkg::CNT_RST;
            st_r.cnt        <= rte_pkg::CNT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all taken from state flip-flops
    // ------------------------------------------------------------------
    // Drives the ports from the registered state.
    assign overflow_event         = st_r.ovf_ev;
    assign compare_match          = st_r.cmp_ev;
    assign tick_levels            = st_r.levels;
    assign irq_flag_register      = st_r.flags;
    assign tick_irq_flag_register = st_r.tick_flag;
    assign counter_irq            = st_r.cnt_irq;
    assign tick_irq               = st_r.tk_irq;
    assign status_busy            = '{compare_sync_pending:      st_r.sy_cmp.busy,
                                      wrap_limit_sync_pending:   st_r.sy_per.busy,
                                      tick_value_sync_pending:   st_r.sy_cnt.busy,
                                      main_control_sync_pending: st_r.sy_main.busy};
    assign tick_control_sync_pending = st_r.sy_tick.busy;
    assign tick_value             = st_r.cnt;

endmodule // rte_top

// ### rte_top_properties.sv
// Concurrent checks on the ports of the event, interrupt and halt block.
// Assumes it is bound to rte_top and sees its ports only.
`timescale 1ns/1ps
module rte_top_properties (
    // Clock and reset
    input wire logic                         clk_sys,
    input wire logic                         reset_n,
    // Inputs watched
    input wire logic                         cpu_halted,
    input wire logic                         keep_running_when_halted,
    input wire logic                         tick_keep_running_when_halted,
    input wire logic                         compare_wr,
    input wire logic                         tick_ctrl_wr,
    input wire logic [1:0]                   irq_enable_register,
    input wire logic                         tick_irq_enable_register,
    input wire logic [1:0]                   irq_flag_clear,
    input wire logic                         tick_irq_flag_clear,
    // Outputs watched
    input wire logic                         overflow_event,
    input wire logic                         compare_match,
    input wire logic [rte_pkg::LEVEL_N-1:0]  tick_levels,
    input wire logic [1:0]                   irq_flag_register,
    input wire logic                         tick_irq_flag_register,
    input wire logic                         counter_irq,
    input wire logic                         tick_irq,
    input wire rte_pkg::rte_busy_t           status_busy,
    input wire logic                         tick_control_sync_pending,
    input wire logic [rte_pkg::CNT_W-1:0]    tick_value
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // Counter halted with no tick value write pending for a few cycles.
    sequence s_cnt_held;
        (cpu_halted && !keep_running_when_halted && !status_busy.tick_value_sync_pending)[*4];
    endsequence
    // Tick timer halted without its run bit.
    sequence s_tick_held;
        (cpu_halted && !tick_keep_running_when_halted)[*2];
    endsequence
    chk_irq_raised: assert property (
        |(irq_flag_register & ~irq_flag_clear & irq_enable_register) |=> counter_irq)
        else $error("counter request missing");
    chk_irq_quiet: assert property (
        !(|(irq_flag_register & irq_enable_register)) |=>
            counter_irq == |(irq_flag_register & $past(irq_enable_register)))
        else $error("counter request without enabled flag");
    chk_tick_irq_raised: assert property (
        tick_irq_flag_register && tick_irq_enable_register && !tick_irq_flag_clear |=> tick_irq)
        else $error("tick request missing");
    chk_ovf_flag: assert property (
        $rose(overflow_event) |-> ##[0:1] irq_flag_register[0])
        else $error("overflow flag not set by event");
    chk_cmp_flag: assert property (
        $rose(compare_match) |-> ##[0:1] irq_flag_register[1])
        else $error("compare flag not set by event");
    chk_ovf_pulse: assert property (
        $rose(overflow_event) |=> overflow_event[*3])
        else $error("overflow pulse too short");
    chk_flag_clear: assert property (
        irq_flag_clear[0] && !overflow_event |=> !irq_flag_register[0] || $rose(overflow_event))
        else $error("overflow flag survived a clear");
    chk_busy_rises: assert property (
        compare_wr |=> status_busy.compare_sync_pending)
        else $error("compare busy not set by write");
    chk_tick_busy: assert property (
        tick_ctrl_wr |=> tick_control_sync_pending)
        else $error("tick control busy not set by write");
    chk_count_held: assert property (
        s_cnt_held |=> $stable(tick_value))
        else $error("count moved while halted");
    chk_levels_low: assert property (
        s_tick_held |-> tick_levels == '0)
        else $error("tick levels not low while halted");
endmodule // rte_top_properties

bind rte_top rte_top_properties chk (.clk_sys, .reset_n, .cpu_halted, .keep_running_when_halted,
    .tick_keep_running_when_halted, .compare_wr, .tick_ctrl_wr, .irq_enable_register,
    .tick_irq_enable_register, .irq_flag_clear, .overflow_event, .compare_match, .tick_levels,
    .irq_flag_register, .tick_irq_flag_register, .counter_irq, .tick_irq, .status_busy,
    .tick_control_sync_pending, .tick_value, .tick_irq_flag_clear);

// ### rte_top_test.sv
// Self-checking bench for the event, interrupt, sleep and halt block.
// Assumes the far-end model makes the slow clock at eight system cycles.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module rte_top_test;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clk_sys, reset_n, slow_clk_pin, sleep_idle, sleep_standby, cpu_halted;
    logic main_ctrl_wr, tick_ctrl_wr, compare_wr, wrap_limit_wr, tick_value_wr;
    rte_pkg::rte_main_ctrl_t     main_ctrl_wdata;
    rte_pkg::rte_tick_ctrl_t     tick_ctrl_wdata;
    logic [rte_pkg::CNT_W-1:0]   compare_wdata, wrap_limit_wdata, tick_value_wdata, tick_value, v;
    logic [1:0]                  irq_enable_register, irq_flag_clear, irq_flag_register;
    logic tick_irq_enable_register, keep_running_when_halted, tick_keep_running_when_halted;
    logic tick_irq_flag_clear, overflow_event, compare_match, tick_irq_flag_register;
    logic counter_irq, tick_irq, tick_control_sync_pending;
    logic [rte_pkg::LEVEL_N-1:0] tick_levels;
    rte_pkg::rte_busy_t          status_busy;
    logic [4:0]                  busy_all;
    int                          comparisons, miscompares, ovf_seen, n, w;
    typedef struct packed { logic [1:0] en; logic ten; logic irq; logic tirq; } rte_row_t;
    rte_row_t rows [4] = '{'{2'b00, 1'b0, 1'b0, 1'b0}, '{2'b01, 1'b1, 1'b1, 1'b1},
                           '{2'b10, 1'b0, 1'b1, 1'b0}, '{2'b00, 1'b1, 1'b0, 1'b1}};
    assign busy_all = {tick_control_sync_pending, status_busy};
    rte_top dut (.clk_sys, .reset_n, .slow_clk_pin, .sleep_idle, .sleep_standby, .cpu_halted,
        .main_ctrl_wr, .main_ctrl_wdata, .tick_ctrl_wr, .tick_ctrl_wdata, .compare_wr,
        .compare_wdata, .wrap_limit_wr, .wrap_limit_wdata, .tick_value_wr, .tick_value_wdata,
        .irq_enable_register, .tick_irq_enable_register, .keep_running_when_halted,
        .tick_keep_running_when_halted, .irq_flag_clear, .tick_irq_flag_clear, .overflow_event,
        .compare_match, .tick_levels, .irq_flag_register, .tick_irq_flag_register, .counter_irq,
        .tick_irq, .status_busy, .tick_control_sync_pending, .tick_value);
    rte_far_end far (.slow_clk_pin, .overflow_event, .ovf_seen);
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic tick(input int c);
        repeat (c) @(negedge clk_sys);
    endtask
    // Writes one register: 0 main, 1 count, 2 wrap, 3 compare, 4 tick control.
    task automatic wr(input int k, input logic [15:0] d);
        w = 0;
        while (busy_all[k] !== 1'b0 && w < 100) begin
            tick(1);
            w++;
        end
        tick(1);
        {main_ctrl_wdata, tick_ctrl_wdata} = {d[5:0], d[4:0]};
        {compare_wdata, wrap_limit_wdata, tick_value_wdata} = {d, d, d};
        {tick_ctrl_wr, compare_wr, wrap_limit_wr, tick_value_wr, main_ctrl_wr} = 5'h01 << k;
        tick(1);
        {tick_ctrl_wr, compare_wr, wrap_limit_wr, tick_value_wr, main_ctrl_wr} = 5'h00;
        `CHK("busy set", 1'b1, busy_all[k])
        w = 0;
        while (busy_all[k] !== 1'b0 && w < 40) begin
            tick(1);
            w++;
        end
        `CHK("busy clear", 1'b0, busy_all[k])
    endtask
    task automatic clr_tick();
        tick_irq_flag_clear = 1'b1;
        tick(1);
        tick_irq_flag_clear = 1'b0;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Cuts a hang short well after the tests should have ended.
    initial begin
        #480000;
        miscompares++;
        print_verdict();
    end
    // Main sequence: reset, table of enables, then the awkward cases.
    initial begin
        {reset_n, sleep_idle, sleep_standby, cpu_halted, main_ctrl_wr, tick_ctrl_wr} = '0;
        {compare_wr, wrap_limit_wr, tick_value_wr, main_ctrl_wdata, tick_ctrl_wdata} = '0;
        {compare_wdata, wrap_limit_wdata, tick_value_wdata, irq_enable_register} = '0;
        {tick_irq_enable_register, keep_running_when_halted, irq_flag_clear} = '0;
        {tick_keep_running_when_halted, tick_irq_flag_clear, comparisons, miscompares} = '0;
        tick(20);
        reset_n = 1'b1;
        `CHK("reset state", 24'h0, {busy_all, irq_flag_register, tick_irq_flag_register, tick_value})
        wr(2, 16'h0003);
        wr(3, 16'h0002);
        wr(1, 16'h0001);
        wr(4, 16'h0003);
        wr(0, 16'h0001);
        for (w = 0; overflow_event !== 1'b1 && w < 200; w++) tick(1);
        `CHK("wrap count", 16'h0000, tick_value)
        for (n = 0; overflow_event === 1'b1 && n < 20; n++) tick(1);
        `CHK("pulse length", 8, n)
        `CHK("overflow flag", 1'b1, irq_flag_register[0])
        for (w = 0; compare_match !== 1'b1 && w < 200; w++) tick(1);
        `CHK("match count", 16'h0002, tick_value)
        tick(2);
        `CHK("compare flag", 1'b1, irq_flag_register[1])
        n = ovf_seen;
        tick(256);
        `CHK("pulse count", n + 8, ovf_seen)
        $display("test counting done");
        foreach (rows[i]) begin
            irq_enable_register = rows[i].en;
            tick_irq_enable_register = rows[i].ten;
            tick(2);
            `CHK("counter request", rows[i].irq, counter_irq)
            `CHK("tick request", rows[i].tirq, tick_irq)
        end
        $display("test enables done");
        cpu_halted = 1'b1;
        tick(4);
        v = tick_value;
        tick(40);
        `CHK("halted count", v, tick_value)
        `CHK("halted levels", 8'h00, tick_levels)
        irq_flag_clear = 2'b01;
        clr_tick();
        irq_flag_clear = 2'b00;
        tick(40);
        `CHK("flags after clear", 3'b100, {irq_flag_register, tick_irq_flag_register})
        keep_running_when_halted = 1'b1;
        tick(40);
        `CHK("debug run count", 1'b1, tick_value !== v)
        {cpu_halted, keep_running_when_halted} = 2'b00;
        $display("test halt done");
        sleep_standby = 1'b1;
        clr_tick();
        tick(4);
        v = tick_value;
        tick(40);
        `CHK("standby count", v, tick_value)
        `CHK("standby tick flag", 1'b1, tick_irq_flag_register)
        wr(0, 16'h0021);
        v = tick_value;
        tick(40);
        `CHK("standby run count", 1'b1, tick_value !== v)
        {sleep_standby, sleep_idle} = 2'b01;
        v = tick_value;
        tick(40);
        `CHK("idle count", 1'b1, tick_value !== v)
        $display("test sleep done");
        for (int i = 0; i < 2; i++) begin
            for (w = 0; tick_levels[i] !== 1'b0 && w < 2000; w++) tick(1);
            for (w = 0; tick_levels[i] !== 1'b1 && w < 2000; w++) tick(1);
            for (n = 0; tick_levels[i] === 1'b1 && n < 2000; n++) tick(1);
            `CHK("level half period", 256 << i, n)
        end
        clr_tick();
        for (n = 0; tick_irq_flag_register !== 1'b1 && n < 100; n++) tick(1);
        clr_tick();
        for (n = 0; tick_irq_flag_register !== 1'b1 && n < 100; n++) tick(1);
        // One of the 32 cycles between ticks is spent in the clear.
        `CHK("tick interval", 31, n)
        $display("test tick timer done");
        print_verdict();
    end
endmodule // rte_top_test
